// ### core/bstc_map.svh
// Constants for the transceiver control and test access logic
`ifndef BSTC_MAP_SVH
`define BSTC_MAP_SVH
`define BSTC_NCH          9
`define BSTC_IR_W         8
`define BSTC_IR_CAPTURE   8'h3D
`define BSTC_C0_EXTEST    8'h00
`define BSTC_C0_SAMPLE    8'h82
`define BSTC_C0_CLAMP     8'h87
`define BSTC_C1_EXTEST    8'h99
`define BSTC_C1_SAMPLE    8'h92
`define BSTC_C1_CLAMP     8'h8F
`define BSTC_HIGHZ        8'h06
`define BSTC_BSR_LOGIC    27
`define BSTC_BSR_FULL     45
`define BSTC_BSR_MAX      45
`endif

// ### core/bstc_pkg.sv
// Types for the transceiver control and test access logic
package bstc_pkg;
  typedef enum logic [1:0] {
    BSTC_MODE_Z    = 2'b00,
    BSTC_MODE_RX   = 2'b01,
    BSTC_MODE_TX   = 2'b10,  // Driver on, receiver off
    BSTC_MODE_LOOP = 2'b11   // Driver on, receiver on
  } bstc_mode_t;
  typedef enum logic [3:0] {
    BSTC_RESET = 4'h0, BSTC_IDLE = 4'h1, BSTC_SEL_DR = 4'h3, BSTC_CAP_DR = 4'h2,
    BSTC_SH_DR = 4'h6, BSTC_EX1_DR = 4'h7, BSTC_PA_DR = 4'h5, BSTC_EX2_DR = 4'h4,
    BSTC_UP_DR = 4'hC, BSTC_SEL_IR = 4'hD, BSTC_CAP_IR = 4'hF, BSTC_SH_IR = 4'hE,
    BSTC_EX1_IR = 4'hA, BSTC_PA_IR = 4'hB, BSTC_EX2_IR = 4'h9, BSTC_UP_IR = 4'h8
  } bstc_tap_t;
  typedef enum logic [2:0] {
    BSTC_I_BYPASS, BSTC_I_EXTEST, BSTC_I_SAMPLE, BSTC_I_CLAMP, BSTC_I_HIGHZ
  } bstc_instr_t;
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bstc_tdo_t;
endpackage

// ### core/bstc_top.sv
// Nine channel transceiver control with boundary scan test access port
// Behaviour
// - Enables decode to driver, receiver, high-impedance or loop-back mode.
// - Driver sends true/complement on bus legs, floats both when disabled.
// - Receiver follows differential sign; output floats when receiver disabled.
// - Logic-only chain covers logic pins; full chain adds bus pins.
// - Bypass is one stage and captures zero.
// - Instruction register is eight bits and captures 00111101.
`timescale 1ns/1ps
`default_nettype none
`include "bstc_map.svh"
module bstc_top
  import bstc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 drive_on,
  input  wire logic                 listen_on_n,
  input  wire logic [`BSTC_NCH-1:0] tx_in,
  input  wire logic [`BSTC_NCH-1:0] bus_pos_in,
  input  wire logic [`BSTC_NCH-1:0] bus_neg_in,
  output logic      [`BSTC_NCH-1:0] bus_pos,
  output logic      [`BSTC_NCH-1:0] bus_neg,
  output logic      [`BSTC_NCH-1:0] bus_oe,
  output logic      [`BSTC_NCH-1:0] rx_out,
  output logic      [`BSTC_NCH-1:0] rx_oe,
  input  wire logic                 scan_config_full,
  input  wire logic                 tck,
  input  wire logic                 trst_n,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output bstc_tdo_t                 tdo_o
);
  localparam int BW = `BSTC_BSR_MAX;
  //------------------------------------------------------------
  // Pin synchronisers on the system clock
  //------------------------------------------------------------
  logic [1:0] en_s1_reg, en_s2_reg;
  logic [`BSTC_NCH-1:0] tx_s1_reg, tx_s2_reg, dp_s1_reg, dp_s2_reg, dn_s1_reg, dn_s2_reg;
  // Two stages before any logic reads a pin
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      en_s1_reg <= 2'h2; en_s2_reg <= 2'h2;
      tx_s1_reg <= '0; tx_s2_reg <= '0;
      dp_s1_reg <= '0; dp_s2_reg <= '0; dn_s1_reg <= '0; dn_s2_reg <= '0;
    end else begin
      en_s1_reg <= {listen_on_n, drive_on}; en_s2_reg <= en_s1_reg;
      tx_s1_reg <= tx_in; tx_s2_reg <= tx_s1_reg;
      dp_s1_reg <= bus_pos_in; dp_s2_reg <= dp_s1_reg;
      dn_s1_reg <= bus_neg_in; dn_s2_reg <= dn_s1_reg;
    end
  end
  //------------------------------------------------------------
  // Test clock domain: TAP controller
  //------------------------------------------------------------
  bstc_tap_t tap_reg, tap_next;
  // Next state of the standard sixteen state controller
  always_comb begin
    unique case (tap_reg)
      BSTC_RESET:  tap_next = tms ? BSTC_RESET  : BSTC_IDLE;
      BSTC_IDLE:   tap_next = tms ? BSTC_SEL_DR : BSTC_IDLE;
      BSTC_SEL_DR: tap_next = tms ? BSTC_SEL_IR : BSTC_CAP_DR;
      BSTC_CAP_DR: tap_next = tms ? BSTC_EX1_DR : BSTC_SH_DR;
      BSTC_SH_DR:  tap_next = tms ? BSTC_EX1_DR : BSTC_SH_DR;
      BSTC_EX1_DR: tap_next = tms ? BSTC_UP_DR  : BSTC_PA_DR;
      BSTC_PA_DR:  tap_next = tms ? BSTC_EX2_DR : BSTC_PA_DR;
      BSTC_EX2_DR: tap_next = tms ? BSTC_UP_DR  : BSTC_SH_DR;
      BSTC_UP_DR:  tap_next = tms ? BSTC_SEL_DR : BSTC_IDLE;
      BSTC_SEL_IR: tap_next = tms ? BSTC_RESET  : BSTC_CAP_IR;
      BSTC_CAP_IR: tap_next = tms ? BSTC_EX1_IR : BSTC_SH_IR;
      BSTC_SH_IR:  tap_next = tms ? BSTC_EX1_IR : BSTC_SH_IR;
      BSTC_EX1_IR: tap_next = tms ? BSTC_UP_IR  : BSTC_PA_IR;
      BSTC_PA_IR:  tap_next = tms ? BSTC_EX2_IR : BSTC_PA_IR;
      BSTC_EX2_IR: tap_next = tms ? BSTC_UP_IR  : BSTC_SH_IR;
      BSTC_UP_IR:  tap_next = tms ? BSTC_SEL_DR : BSTC_IDLE;
    endcase
  end
  // State register, asynchronous test reset
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) tap_reg <= BSTC_RESET;
    else         tap_reg <= tap_next;
  end
  //------------------------------------------------------------
  // Instruction and data registers
  //------------------------------------------------------------
  logic [`BSTC_IR_W-1:0] ir_sh_reg, ir_reg;
  logic                  byp_reg;
  logic [BW-1:0]         bsr_sh_reg, bsr_up_reg;
  logic                  cfg_full;
  bstc_instr_t           instr;
  logic                  cfg_s1_reg, cfg_s2_reg;
  // Configuration pin, two stages on the test clock before decode reads it
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      cfg_s1_reg <= 1'b0;
      cfg_s2_reg <= 1'b0;
    end else begin
      cfg_s1_reg <= scan_config_full;
      cfg_s2_reg <= cfg_s1_reg;
    end
  end
  assign cfg_full = cfg_s2_reg;
  always_comb begin
    instr = BSTC_I_BYPASS;
    if (ir_reg == `BSTC_HIGHZ) instr = BSTC_I_HIGHZ;
    else if (!cfg_full) begin
      if (ir_reg == `BSTC_C0_EXTEST) instr = BSTC_I_EXTEST;
      else if (ir_reg == `BSTC_C0_SAMPLE) instr = BSTC_I_SAMPLE;
      else if (ir_reg == `BSTC_C0_CLAMP) instr = BSTC_I_CLAMP;
    end else begin
      if (ir_reg == `BSTC_C1_EXTEST) instr = BSTC_I_EXTEST;
      else if (ir_reg == `BSTC_C1_SAMPLE) instr = BSTC_I_SAMPLE;
      else if (ir_reg == `BSTC_C1_CLAMP) instr = BSTC_I_CLAMP;
    end
  end
  // eight-bit capture and shift, reset to bypass code
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh_reg <= 8'hFF; ir_reg <= 8'hFF;
    end else begin
      if (tap_reg == BSTC_CAP_IR) ir_sh_reg <= `BSTC_IR_CAPTURE;
      else if (tap_reg == BSTC_SH_IR) ir_sh_reg <= {tdi, ir_sh_reg[`BSTC_IR_W-1:1]};
      if (tap_reg == BSTC_RESET) ir_reg <= 8'hFF;
      else if (tap_reg == BSTC_UP_IR) ir_reg <= ir_sh_reg;
    end
  end
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) byp_reg <= 1'b0;
    else if (tap_reg == BSTC_CAP_DR) byp_reg <= 1'b0;
    else if (tap_reg == BSTC_SH_DR) byp_reg <= tdi;
  end
  // Captured values, crossed from the system clock (static during capture)
  logic [BW-1:0] cap_vec;
  logic [BW-1:0] cap_s1_reg, cap_s2_reg;
  logic          bsr_act;
  logic [5:0]    bsr_len;
  // logic pins always; bus pins only in the full chain
  always_comb begin
    cap_vec = '0;
    cap_vec[8:0]   = tx_s2_reg;
    cap_vec[17:9]  = rx_out;
    cap_vec[26:18] = {7'h00, en_s2_reg};
    if (cfg_full) begin
      cap_vec[35:27] = dp_s2_reg;
      cap_vec[44:36] = dn_s2_reg;
    end
  end
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      cap_s1_reg <= '0; cap_s2_reg <= '0;
    end else begin
      cap_s1_reg <= cap_vec; cap_s2_reg <= cap_s1_reg;
    end
  end
  assign bsr_act = (instr == BSTC_I_EXTEST) || (instr == BSTC_I_SAMPLE);
  assign bsr_len = cfg_full ? 6'd`BSTC_BSR_FULL : 6'd`BSTC_BSR_LOGIC;
  // boundary chain, serial entry at the configured length
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      bsr_sh_reg <= '0; bsr_up_reg <= '0;
    end else if (bsr_act) begin
      if (tap_reg == BSTC_CAP_DR) bsr_sh_reg <= cap_s2_reg;
      else if (tap_reg == BSTC_SH_DR) begin
        bsr_sh_reg <= bsr_sh_reg >> 1;
        bsr_sh_reg[bsr_len-6'd1] <= tdi;
      end
      if (tap_reg == BSTC_UP_DR) bsr_up_reg <= bsr_sh_reg;
    end
  end
  // Serial output changes on the falling edge
  bstc_tdo_t tdo_reg;
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) tdo_reg <= '0;
    else begin
      tdo_reg.tdo_oe <= (tap_reg == BSTC_SH_IR) || (tap_reg == BSTC_SH_DR);
      tdo_reg.tdo <= (tap_reg == BSTC_SH_IR) ? ir_sh_reg[0] : (bsr_act ? bsr_sh_reg[0] : byp_reg);
    end
  end
  assign tdo_o = tdo_reg;
  // Test control levels to the system clock
  logic [2:0] tctl, tctl_s1_reg, tctl_s2_reg;
  logic [BW-1:0] upd_s1_reg, upd_s2_reg;
  assign tctl = {instr == BSTC_I_EXTEST, instr == BSTC_I_CLAMP, instr == BSTC_I_HIGHZ};
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tctl_s1_reg <= '0; tctl_s2_reg <= '0; upd_s1_reg <= '0; upd_s2_reg <= '0;
    end else begin
      tctl_s1_reg <= tctl; tctl_s2_reg <= tctl_s1_reg;
      upd_s1_reg <= bsr_up_reg; upd_s2_reg <= upd_s1_reg;
    end
  end
  //------------------------------------------------------------
  // Functional path
  //------------------------------------------------------------
  bstc_mode_t mode;
  logic [1:0] en_eff;
  logic       forced, tst_z;
  logic [`BSTC_NCH-1:0] tx_eff;
  assign forced = tctl_s2_reg[2] | tctl_s2_reg[1];
  assign tst_z  = tctl_s2_reg[0];
  assign en_eff = forced ? upd_s2_reg[19:18] : en_s2_reg;
  assign tx_eff = forced ? upd_s2_reg[8:0] : tx_s2_reg;
  assign mode = bstc_mode_t'({en_eff[0], ~en_eff[1]});
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_pos <= '0; bus_neg <= '0; bus_oe <= '0; rx_out <= '0; rx_oe <= '0;
    end else begin
      bus_oe  <= (!tst_z && (mode == BSTC_MODE_TX || mode == BSTC_MODE_LOOP)) ? '1 : '0;
      bus_pos <= tx_eff;
      bus_neg <= ~tx_eff;
      rx_oe   <= (!tst_z && (mode == BSTC_MODE_RX || mode == BSTC_MODE_LOOP)) ? '1 : '0;
      rx_out  <= (tctl_s2_reg[1]) ? upd_s2_reg[17:9]
               : ((mode == BSTC_MODE_LOOP) ? tx_eff : (dp_s2_reg & ~dn_s2_reg));
    end
  end
  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  chk_drive_legs: assert property (@(posedge mclk) disable iff (!rst_n)
    bus_oe[0] |-> bus_pos[0] != bus_neg[0]) else $error("bus legs not complementary");
  chk_mode_enable: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == BSTC_MODE_Z && !forced) |=> !bus_oe[0] && !rx_oe[0]) else $error("z mode drove");
  chk_rx_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == BSTC_MODE_RX && !forced && dp_s2_reg[0] && !dn_s2_reg[0]) |=> rx_out[0])
    else $error("receiver wrong");
  chk_bypass_zero: assert property (@(posedge tck) disable iff (!trst_n)
    tap_reg == BSTC_CAP_DR |=> !byp_reg) else $error("bypass not zero");
  chk_ir_capture: assert property (@(posedge tck) disable iff (!trst_n)
    tap_reg == BSTC_CAP_IR |=> ir_sh_reg == `BSTC_IR_CAPTURE) else $error("ir capture wrong");
  chk_ir_shift: assert property (@(posedge tck) disable iff (!trst_n)
    tap_reg == BSTC_SH_IR |=> ir_sh_reg[7] == $past(tdi)) else $error("ir shift wrong");
  chk_cfg0_decode: assert property (@(posedge tck) disable iff (!trst_n)
    (!cfg_full && ir_reg == 8'h99) |-> instr == BSTC_I_BYPASS) else $error("cfg0 decode");
  chk_cfg1_decode: assert property (@(posedge tck) disable iff (!trst_n)
    (cfg_full && ir_reg == 8'h99) |-> instr == BSTC_I_EXTEST) else $error("cfg1 decode");
  chk_chain_len: assert property (@(posedge tck) disable iff (!trst_n)
    bsr_len == (cfg_full ? 6'd45 : 6'd27)) else $error("chain length");
  cov_ir_update: cover property (@(posedge tck) tap_reg == BSTC_UP_IR);
  cov_extest: cover property (@(posedge tck) instr == BSTC_I_EXTEST);
  cov_loop: cover property (@(posedge mclk) mode == BSTC_MODE_LOOP);
endmodule
`default_nettype wire

// ### verif/bstc_tap_host.sv
// Scan test controller model driving the test access port
`timescale 1ns/1ps
`default_nettype none
module bstc_tap_host (
  output logic      tck,
  output logic      trst_n,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // ------------------------------------------------------------
  // Idle levels; the test clock stands still between frames
  // ------------------------------------------------------------
  // Test reset falls after time zero so the design surely sees its edge
  initial begin
    tck = 1'b0;
    trst_n = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
    #1 trst_n = 1'b0;
  end

  // One 12 ns test clock period; data is taken back at the rising edge
  task automatic tick(input logic m, input logic d, output logic s);
    tms = m;
    tdi = d;
    #6 tck = 1'b1;
    s = tdo;
    #6 tck = 1'b0;
  endtask

  // Step without shifting; the data line toggles so it never looks held
  task automatic go(input logic m);
    logic s;
    tick(m, ~tdi, s);
  endtask

  // Async reset pulse, five high mode cycles, then into idle
  task automatic reset_tap();
    trst_n = 1'b0;
    #20 trst_n = 1'b1;
    repeat (5) go(1'b1);
    go(1'b0);
  endtask

  // Instruction or data scan of n bits, first bit first, ending in idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic s;
    dout = '0;
    go(1'b1);
    if (ir) go(1'b1);
    go(1'b0);
    go(1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], s);
      dout[i] = s;
    end
    go(1'b1);
    go(1'b0);
  endtask
endmodule
`default_nettype wire

// ### verif/bstc_top_test.sv
// Testbench for the transceiver control and scan port
`timescale 1ns/1ps
`default_nettype none
module bstc_top_test import bstc_pkg::*;;
  logic            mclk;
  logic            rst_n;
  logic            drive_on;
  logic            listen_on_n;
  logic            scan_config_full;
  logic [8:0]      tx_in;
  logic [8:0]      far_pos;
  logic [8:0]      far_neg;
  logic [8:0]      bus_pos_in;
  logic [8:0]      bus_neg_in;
  logic [8:0]      bus_pos;
  logic [8:0]      bus_neg;
  logic [8:0]      bus_oe;
  logic [8:0]      rx_out;
  logic [8:0]      rx_oe;
  logic            tck;
  logic            trst_n;
  logic            tms;
  logic            tdi;
  bstc_tdo_t       tdo_o;
  logic [63:0]     q;
  int              n_fail;
  int              checks;

  // Wire level of each leg from both parties
  assign bus_pos_in = (bus_oe & bus_pos) | (~bus_oe & far_pos);
  assign bus_neg_in = (bus_oe & bus_neg) | (~bus_oe & far_neg);

  bstc_top i_bstc_top (.mclk, .rst_n, .drive_on, .listen_on_n, .tx_in, .bus_pos_in, .bus_neg_in, .bus_pos,
    .bus_neg, .bus_oe, .rx_out, .rx_oe, .scan_config_full, .tck, .trst_n, .tms, .tdi, .tdo_o);
  // A released serial output shows the inverse so an early sample is caught
  bstc_tap_host i_bstc_tap_host (.tck, .trst_n, .tms, .tdi, .tdo(tdo_o.tdo_oe ? tdo_o.tdo : ~tdo_o.tdo));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic set_pins(input logic d, input logic r, input logic [8:0] tx, input logic [8:0] p);
    @(posedge mclk);
    drive_on <= d;
    listen_on_n <= r;
    tx_in <= tx;
    far_pos <= p;
    far_neg <= ~p;
    repeat (6) @(posedge mclk);
    #1;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_modes();
    logic [8:0] tx;
    for (int m = 0; m < 4; m++) begin
      tx = 9'h0C3 ^ {9{m[0]}};
      set_pins(m[1], m[0], tx, 9'h1A5);
      check(bus_oe, {9{m[1]}}, "bus enable");
      check(rx_oe, {9{~m[0]}}, "receiver enable");
      if (m[1]) check({bus_neg, bus_pos}, {~tx, tx}, "driver legs");
      if (!m[0]) check(rx_out, m[1] ? tx : 9'h1A5, "receiver output");
    end
    $display("test modes done");
  endtask

  task automatic test_decode(input logic cfg);
    logic [7:0] codes [6];
    int         blen;
    blen = cfg ? 45 : 27;
    if (cfg) codes = '{8'h99, 8'h92, 8'h8F, 8'h06, 8'h00, 8'h82};
    else codes = '{8'h00, 8'h82, 8'h87, 8'h06, 8'h99, 8'hFF};
    @(posedge mclk);
    scan_config_full <= cfg;
    set_pins(1'b0, 1'b1, 9'h15A, 9'h000);
    i_bstc_tap_host.reset_tap();
    for (int k = 0; k < 6; k++) begin
      i_bstc_tap_host.scan(1'b1, 8, {56'h0, codes[k]}, q);
      check(q[7:0], 8'h3D, "instruction capture");
      i_bstc_tap_host.scan(1'b0, 64, 64'h1, q);
      if (k < 2) begin
        check(q >> blen, 64'h1, "boundary length");
        check(q[8:0], 9'h15A, "boundary capture");
      end else
        check(q, 64'h2, "bypass path");
    end
    $display("test decode done");
  endtask

  task automatic test_highz();
    set_pins(1'b1, 1'b0, 9'h0F0, 9'h000);
    i_bstc_tap_host.scan(1'b1, 8, 64'h6, q);
    repeat (8) @(posedge mclk);
    #1;
    check({bus_oe, rx_oe}, 18'h0, "floating outputs");
    i_bstc_tap_host.go(1'b1);
    i_bstc_tap_host.go(1'b0);
    i_bstc_tap_host.go(1'b0);
    #1;
    check(tdo_o.tdo_oe, 1'b1, "serial output enabled in shift");
    i_bstc_tap_host.go(1'b1);
    i_bstc_tap_host.go(1'b1);
    i_bstc_tap_host.go(1'b0);
    #1;
    check(tdo_o.tdo_oe, 1'b0, "serial output released in idle");
    i_bstc_tap_host.scan(1'b1, 8, 64'hFF, q);
    repeat (8) @(posedge mclk);
    #1;
    check({bus_oe, rx_oe}, {18{1'b1}}, "outputs restored");
    $display("test highz done");
  endtask

  // ------------------------------------------------------------
  // Clock, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    rst_n = 1'b0;
    drive_on = 1'b0;
    listen_on_n = 1'b1;
    scan_config_full = 1'b0;
    tx_in = 9'h000;
    far_pos = 9'h000;
    far_neg = 9'h1FF;
    n_fail = 0;
    checks = 0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    test_modes();
    test_decode(1'b0);
    test_decode(1'b1);
    test_highz();
    complete_run();
  end

  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
